// *** hw/shlc_line_mux.sv ***
// Per-line override: pass the internal condition or force the line active
`timescale 1ns/1ns

module shlc_line_mux
#(
    parameter int N_LINES = 3
)
(
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic [N_LINES-1:0]   cond,
    input  wire logic [N_LINES-1:0]   force_on,
    input  wire logic                 enable,
    output logic      [N_LINES-1:0]   line_q
);

    // ----------------------------------------------------------------
    // One registered output per line
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_LINES; g = g + 1)
        begin : gen_line
            // Forced lines stay on whatever the condition, but only while enable is high
            always_ff @(posedge mclk)
            begin
                if (reset)
                    line_q[g] <= 1'b0;
                else
                    line_q[g] <= enable && (force_on[g] || cond[g]); // [R4] [R5] [R11]
            end
        end
    endgenerate

endmodule

// *** hw/shlc_map.svh ***
// Register offsets, field positions, reset values and codes for the handshake line control block
`ifndef SHLC_MAP_SVH
`define SHLC_MAP_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define SHLC_ADDR_W         4
`define SHLC_REG_MODE       4'h0
`define SHLC_REG_LINE_CTRL  4'h1
`define SHLC_REG_LINE_STAT  4'h2
`define SHLC_REG_INPUTS     4'h3

// ----------------------------------------------------------------
// Line control field positions
// ----------------------------------------------------------------
`define SHLC_CTRL_RTS_LSB   0
`define SHLC_CTRL_CTS_BIT   2
`define SHLC_CTRL_DCD_BIT   3
`define SHLC_CTRL_DTR_BIT   4
`define SHLC_CTRL_DSR_BIT   5

// ----------------------------------------------------------------
// Line status bit positions
// ----------------------------------------------------------------
`define SHLC_STAT_RTS       0
`define SHLC_STAT_CTS       1
`define SHLC_STAT_DCD       2
`define SHLC_STAT_DTR       3
`define SHLC_STAT_DSR       4
`define SHLC_STAT_CARRIER   5
`define SHLC_STAT_EN        6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SHLC_MODE_RST       3'h0
`define SHLC_CTRL_RST       6'h00

// ----------------------------------------------------------------
// Request-to-send handling codes
// ----------------------------------------------------------------
`define SHLC_RTS_NORMAL     2'h0
`define SHLC_RTS_CARRIER    2'h1
`define SHLC_RTS_IGNORE     2'h2

`endif

// *** hw/shlc_mode_decode.sv ***
// Interface standard decoder: one-hot select for the line driver transceivers
`timescale 1ns/1ns
`include "shlc_map.svh"

module shlc_mode_decode
#(
    parameter int N_MODES = 8
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic [2:0]             mode_code,
    input  wire logic                   option_card,
    output logic      [N_MODES-1:0]     std_sel_q,
    output logic                        option_sel_q,
    output logic                        port_en_q
);

    // ----------------------------------------------------------------
    // Decoded selects, one flip-flop per code
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_MODES; g = g + 1)
        begin : gen_sel
            // Standard select for code g; code zero never drives a standard
            always_ff @(posedge mclk)
            begin
                if (reset)
                    std_sel_q[g] <= 1'b0;
                else
                    std_sel_q[g] <= (g != 0) && (mode_code == 3'(g)); // [R1]
            end
        end
    endgenerate

    // Code zero goes to the option card when fitted, else disables
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            option_sel_q <= 1'b0;
            port_en_q    <= 1'b0;
        end
        else
        begin
            option_sel_q <= (mode_code == 3'h0) && option_card;          // [R2]
            port_en_q    <= (mode_code != 3'h0) || option_card;          // [R1] [R2]
        end
    end

endmodule

// *** hw/shlc_pkg.sv ***
// Types shared by the handshake line control block
package shlc_pkg;

    // Electrical interface standard selected by the mode code
    typedef enum logic [2:0] {
        SHLC_IF_OFF,
        SHLC_IF_RS232,
        SHLC_IF_RS449,
        SHLC_IF_RS449_UNTERM,
        SHLC_IF_V35,
        SHLC_IF_V36,
        SHLC_IF_EIA530,
        SHLC_IF_EIA530A
    } shlc_if_mode_t;

    // Software settings for every handshake line
    typedef struct packed {
        logic [1:0] rts_mode;
        logic       cts_force;
        logic       dcd_force;
        logic       dtr_ignore;
        logic       dsr_force;
    } shlc_ctrl_t;

    // Levels presented on the handshake lines
    typedef struct packed {
        logic carrier_gated_by_request;
        logic dsr;
        logic dtr;
        logic dcd;
        logic cts;
        logic rts;
    } shlc_lines_t;

endpackage

// *** hw/shlc_top.sv ***
// Handshake line control and status for the synchronous terrestrial data port
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "shlc_map.svh"

// Notes on behaviour
// (R1) Mode code zero disables the port; codes one to seven pick interface standards.
// (R2) With an option card fitted, code zero selects that card's interface instead.
// (R3) Request handling: 0 normal, 1 request gates carrier, 2 request ignored.
// (R4) Clear-to-send setting 1 forces the line active regardless of internal state.
// (R5) Carrier-detect setting 1 forces the line active even without receive lock.
// (R6) Terminal-ready setting 1 makes the incoming level be disregarded.
// (R7) Incoming request level is readable; writes to it do nothing.
// (R8) Present clear-to-send output level is readable.
// (R9) Present carrier-detect output level is readable.
// (R10) Present terminal-ready input and set-ready output levels are readable.
// (R11) Set-ready setting 1 forces the line active while the port is enabled.
// (R12) Under carrier gating the terminal raises request only when carrier is wanted.
module shlc_top
#(
    parameter int ADDR_W = `SHLC_ADDR_W,
    parameter int DATA_W = 32
)
(
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic                option_card,
    input  wire logic                rts_in,
    input  wire logic                dtr_in,
    input  wire logic                tx_ready,
    input  wire logic                rx_lock,
    input  wire logic                tx_carrier_req,
    output logic                     cts_out,
    output logic                     dcd_out,
    output logic                     dsr_out,
    output logic                     tx_carrier_on,
    output logic                     terminal_ready,
    output logic      [7:0]          std_sel,
    output logic                     option_sel,
    output logic                     port_en
);

    // ----------------------------------------------------------------
    // Settings registers
    // ----------------------------------------------------------------
    shlc_pkg::shlc_if_mode_t mode_q;
    shlc_pkg::shlc_ctrl_t    ctrl_q;

    // Mode register write
    always_ff @(posedge mclk)
    begin
        if (reset)
            mode_q <= shlc_pkg::shlc_if_mode_t'(`SHLC_MODE_RST);
        else if (reg_wr && reg_addr == `SHLC_REG_MODE)
            mode_q <= shlc_pkg::shlc_if_mode_t'(reg_wdata[2:0]); // [R1]
    end

    // Line control register write; reserved request code 3 is stored as written and handled as normal
    always_ff @(posedge mclk)
    begin
        if (reset)
            ctrl_q <= shlc_pkg::shlc_ctrl_t'(`SHLC_CTRL_RST);
        else if (reg_wr && reg_addr == `SHLC_REG_LINE_CTRL)
        begin
            ctrl_q.rts_mode   <= reg_wdata[`SHLC_CTRL_RTS_LSB +: 2]; // [R3]
            ctrl_q.cts_force  <= reg_wdata[`SHLC_CTRL_CTS_BIT];      // [R4]
            ctrl_q.dcd_force  <= reg_wdata[`SHLC_CTRL_DCD_BIT];      // [R5]
            ctrl_q.dtr_ignore <= reg_wdata[`SHLC_CTRL_DTR_BIT];      // [R6]
            ctrl_q.dsr_force  <= reg_wdata[`SHLC_CTRL_DSR_BIT];      // [R11]
        end
    end

    // ----------------------------------------------------------------
    // Interface standard select
    // ----------------------------------------------------------------
    logic port_en_w;

    shlc_mode_decode #(
        .N_MODES (8)
    ) shlc_mode_decode_inst (
        .mclk         (mclk),
        .reset        (reset),
        .mode_code    (mode_q),
        .option_card  (option_card),
        .std_sel_q    (std_sel),
        .option_sel_q (option_sel),
        .port_en_q    (port_en_w)
    );

    assign port_en = port_en_w;

    // ----------------------------------------------------------------
    // Incoming line capture
    // ----------------------------------------------------------------
    logic rts_q;
    logic dtr_q;

    // Registered copies of the terminal's request and ready lines
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rts_q <= 1'b0;
            dtr_q <= 1'b0;
        end
        else
        begin
            rts_q <= rts_in; // [R7]
            dtr_q <= dtr_in; // [R10]
        end
    end

    // Effective request and ready after the handling settings
    logic rts_eff;
    logic dtr_eff;
    logic carrier_gated_by_request;

    always_comb
    begin
        carrier_gated_by_request = (ctrl_q.rts_mode == `SHLC_RTS_CARRIER); // [R3]
        case (ctrl_q.rts_mode)
            `SHLC_RTS_NORMAL:  rts_eff = rts_q;   // [R3]
            `SHLC_RTS_CARRIER: rts_eff = rts_q;   // [R3] [R12]
            `SHLC_RTS_IGNORE:  rts_eff = 1'b1;    // [R3]
            default:           rts_eff = rts_q;
        endcase
        dtr_eff = ctrl_q.dtr_ignore ? 1'b1 : dtr_q; // [R6]
    end

    // ----------------------------------------------------------------
    // Transmit carrier control
    // ----------------------------------------------------------------
    logic carrier_q;

    // Under gating carrier needs both the request level and the modulator's ask; otherwise the modulator asks
    always_ff @(posedge mclk)
    begin
        if (reset)
            carrier_q <= 1'b0;
        else if (!port_en_w)
            carrier_q <= 1'b0;
        else if (carrier_gated_by_request)
            carrier_q <= rts_q && tx_carrier_req; // [R3] [R12]
        else
            carrier_q <= tx_carrier_req;
    end

    assign tx_carrier_on = carrier_q;

    // Terminal ready as seen by the modem after the ignore setting
    always_ff @(posedge mclk)
    begin
        if (reset)
            terminal_ready <= 1'b0;
        else
            terminal_ready <= port_en_w && dtr_eff; // [R6]
    end

    // ----------------------------------------------------------------
    // Outgoing line levels
    // ----------------------------------------------------------------
    logic [2:0] out_cond;
    logic [2:0] out_force;
    logic [2:0] out_q;

    // Internal conditions: ready to send, receive lock, powered and enabled
    always_comb
    begin
        out_cond[0]  = tx_ready && rts_eff; // [R3]
        out_cond[1]  = rx_lock;
        out_cond[2]  = 1'b1;
        out_force[0] = ctrl_q.cts_force;    // [R4]
        out_force[1] = ctrl_q.dcd_force;    // [R5]
        out_force[2] = ctrl_q.dsr_force;    // [R11]
    end

    shlc_line_mux #(
        .N_LINES (3)
    ) shlc_line_mux_inst (
        .mclk     (mclk),
        .reset    (reset),
        .cond     (out_cond),
        .force_on (out_force),
        .enable   (port_en_w),
        .line_q   (out_q)
    );

    assign cts_out = out_q[0];
    assign dcd_out = out_q[1];
    assign dsr_out = out_q[2];

    // ----------------------------------------------------------------
    // Read-back of settings and line levels
    // ----------------------------------------------------------------
    shlc_pkg::shlc_lines_t lines;

    always_comb
    begin
        lines.rts                      = rts_q;     // [R7]
        lines.cts                      = out_q[0];  // [R8]
        lines.dcd                      = out_q[1];  // [R9]
        lines.dtr                      = dtr_q;     // [R10]
        lines.dsr                      = out_q[2];  // [R10]
        lines.carrier_gated_by_request = carrier_q;
    end

    // Read data registered one cycle after the strobe; status is not writable
    always_ff @(posedge mclk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            reg_rdata <= '0;
            case (reg_addr)
                `SHLC_REG_MODE:
                    reg_rdata[2:0] <= mode_q;
                `SHLC_REG_LINE_CTRL:
                    reg_rdata[5:0] <= ctrl_q;
                `SHLC_REG_LINE_STAT:
                begin
                    reg_rdata[`SHLC_STAT_RTS] <= lines.rts;  // [R7]
                    reg_rdata[`SHLC_STAT_CTS] <= lines.cts;  // [R8]
                    reg_rdata[`SHLC_STAT_DCD] <= lines.dcd;  // [R9]
                    reg_rdata[`SHLC_STAT_DTR] <= lines.dtr;  // [R10]
                    reg_rdata[`SHLC_STAT_DSR] <= lines.dsr;  // [R10]
                    reg_rdata[`SHLC_STAT_CARRIER] <= lines.carrier_gated_by_request;
                    reg_rdata[`SHLC_STAT_EN]  <= port_en_w;
                end
                `SHLC_REG_INPUTS:
                    reg_rdata[2:0] <= {option_card, rx_lock, tx_ready};
                default:
                    reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

endmodule

// *** sim/shlc_term_model.sv ***
// Attached terminal equipment: drives request and terminal-ready, promptly or slowly
`timescale 1ns/1ns

module shlc_term_model
(
    input  wire logic mclk,
    input  wire logic want_rts,
    input  wire logic want_dtr,
    input  wire logic slow,
    output logic      rts_in,
    output logic      dtr_in
);
    logic [2:0] rts_q;
    logic [2:0] dtr_q;

    // Request follows want_rts and ready follows want_dtr; slow mode lags three cycles
    always_ff @(posedge mclk)
    begin
        rts_q <= {rts_q[1:0], want_rts};
        dtr_q <= {dtr_q[1:0], want_dtr};
    end
    assign rts_in = slow ? rts_q[2] : rts_q[0];
    assign dtr_in = slow ? dtr_q[2] : dtr_q[0];
endmodule

// *** sim/shlc_top_props.sv ***
// Concurrent checks on the ports of the handshake line control block
`timescale 1ns/1ns

module shlc_top_props
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32
)
(
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              rx_lock,
    input wire logic              tx_carrier_req,
    input wire logic              cts_out,
    input wire logic              dcd_out,
    input wire logic              dsr_out,
    input wire logic              tx_carrier_on,
    input wire logic [7:0]        std_sel,
    input wire logic              option_sel,
    input wire logic              port_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    AST_STD_ZERO: assert property (!std_sel[0] && $onehot0(std_sel)) else $error("std select bad");
    AST_STD_EN: assert property (port_en && !option_sel |-> $onehot(std_sel)) else $error("no standard");
    AST_OFF: assert property (!port_en |=> !(cts_out | dcd_out | dsr_out)) else $error("line on while off");
    AST_OPTION: assert property (option_sel |-> port_en && std_sel == 8'h00) else $error("option bad");
    AST_CARRIER: assert property (tx_carrier_on |-> $past(tx_carrier_req)) else $error("carrier unasked");
    AST_DSR: assert property (port_en [*3] |-> dsr_out) else $error("set ready low");
    AST_DCD: assert property ((rx_lock && port_en) [*3] |-> dcd_out) else $error("carrier detect low");
    AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data not zero");
    AST_STAT: assert property ($past(reg_rd && reg_addr == 2) |->
        reg_rdata[2:1] == {$past(dcd_out), $past(cts_out)}) else $error("status lines wrong");
    AST_STAT_DSR: assert property ($past(reg_rd && reg_addr == 2) |->
        reg_rdata[4] == $past(dsr_out) && reg_rdata[6] == $past(port_en)) else $error("status dsr wrong");

    // Main scenarios reached
    COV_OPT: cover property (option_sel);
    COV_CARRIER: cover property (tx_carrier_on);
    COV_CTS: cover property (cts_out && dcd_out);
endmodule

bind shlc_top shlc_top_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) shlc_top_props_inst (.mclk(mclk),
    .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_lock(rx_lock),
    .tx_carrier_req(tx_carrier_req), .cts_out(cts_out), .dcd_out(dcd_out), .dsr_out(dsr_out),
    .tx_carrier_on(tx_carrier_on), .std_sel(std_sel), .option_sel(option_sel), .port_en(port_en));

// *** sim/shlc_top_test.sv ***
// Self-checking testbench for the handshake line control block
`timescale 1ns/1ns

module shlc_top_test;
    logic        mclk, reset, reg_wr, reg_rd, option_card, tx_ready, rx_lock, tx_carrier_req;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        rts_in, dtr_in, want_rts, want_dtr, slow, rd_prev;
    logic        cts_out, dcd_out, dsr_out, tx_carrier_on, terminal_ready, option_sel, port_en;
    logic [7:0]  std_sel;
    logic [31:0] exp_q[$];
    int          err_count, checks;
    logic [1:0]  rm;
    logic [3:0]  f;
    logic        ec, ex;

    shlc_top shlc_top_inst (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .option_card(option_card),
        .rts_in(rts_in), .dtr_in(dtr_in), .tx_ready(tx_ready), .rx_lock(rx_lock),
        .tx_carrier_req(tx_carrier_req), .cts_out(cts_out), .dcd_out(dcd_out), .dsr_out(dsr_out),
        .tx_carrier_on(tx_carrier_on), .terminal_ready(terminal_ready), .std_sel(std_sel),
        .option_sel(option_sel), .port_en(port_en));
    shlc_term_model shlc_term_model_inst (.mclk(mclk), .want_rts(want_rts), .want_dtr(want_dtr),
        .slow(slow), .rts_in(rts_in), .dtr_in(dtr_in));

    // ------------------------------------------------
    // Clock, tasks
    // ------------------------------------------------
    initial
    begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
        @(posedge mclk);
    endtask

    // Read: note the expected word, the monitor compares when the data stands
    task automatic rd(logic [3:0] a, logic [31:0] e);
        exp_q.push_back(e);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 0;
        @(posedge mclk);
    endtask

    // Monitor: read data is valid only in the cycle after the strobe
    always @(posedge mclk) rd_prev <= reg_rd;
    always @(negedge mclk)
        if (rd_prev)
            check("rdata", reg_rdata, exp_q.pop_front());

    // Watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        stop_test();
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        {reset, reg_wr, reg_rd, option_card, tx_ready, rx_lock, tx_carrier_req} = 7'h7f & 7'h40;
        {want_rts, want_dtr, slow, reg_addr, reg_wdata} = '0;
        void'($urandom(27069));
        repeat (5) @(posedge mclk);
        reset <= 0;
        @(posedge mclk);
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        rd(4'h9, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++)
        begin
            wr(4'h0, 32'(c));
            repeat (3) @(posedge mclk);
            check("std_sel", 32'(std_sel), c == 0 ? 32'h0 : 32'h1 << c);
            check("port_en", 32'(port_en), 32'(c != 0));
            rd(4'h0, 32'(c));
        end
        wr(4'h0, 32'h0);
        option_card <= 1;
        tx_ready <= 1;
        repeat (3) @(posedge mclk);
        check("option", {option_sel, port_en, std_sel}, 32'h300);
        rd(4'h3, 32'h5);
        option_card <= 0;
        $display("test modes done");
        wr(4'h0, 32'h1);
        for (int i = 0; i < 40; i++)
        begin
            rm = 2'($urandom);
            f = 4'($urandom);
            {tx_ready, rx_lock, tx_carrier_req, want_rts, want_dtr, slow} <= 6'($urandom);
            wr(4'h1, {26'h0, f[3], f[2], f[1], f[0], rm});
            repeat (6) @(posedge mclk);
            ec = f[0] | (tx_ready & (rm == 2 ? 1'b1 : rts_in));
            ex = rm == 1 ? rts_in & tx_carrier_req : tx_carrier_req;
            check("cts", 32'(cts_out), 32'(ec));
            check("dcd", 32'(dcd_out), 32'(f[1] | rx_lock));
            check("dsr", 32'(dsr_out), 32'h1);
            check("carrier", 32'(tx_carrier_on), 32'(ex));
            check("dtr", 32'(terminal_ready), 32'(f[2] | dtr_in));
            rd(4'h1, {26'h0, rm, f[0], f[1], f[2], f[3]});
            wr(4'h2, 32'hffff_ffff);
            rd(4'h2, {26'h1, ex, 1'b1, dtr_in, f[1] | rx_lock, ec, rts_in});
        end
        $display("test lines done");
        wr(4'h1, 32'h3c);
        wr(4'h0, 32'h0);
        repeat (4) @(posedge mclk);
        check("off", {cts_out, dcd_out, dsr_out, tx_carrier_on, port_en}, 32'h0);
        $display("test disable done");
        check("queue", 32'(exp_q.size()), 32'h0);
        stop_test();
    end
endmodule
